//--- hw/svm_pkg.sv
package svm_pkg;
  localparam int ADDR_W = 20;
  // Register byte addresses on the plain register port
  localparam logic [19:0] CTRL_ADDR = 20'hFFFA9;
  localparam logic [19:0] LVLS_ADDR = 20'hFFFAA;
  localparam logic [19:0] RSRC_ADDR = 20'hFFFA8;
  // Field positions
  localparam int CTRL_WE_BIT = 7;
  localparam int CTRL_MSK_BIT = 1;
  localparam int CTRL_FLG_BIT = 0;
  localparam int LVLS_MODE_BIT = 7;
  localparam int LVLS_LEVEL_BIT = 0;
  localparam int RSRC_MON_BIT = 0;
  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] LVLS_RST_COMB = 8'h00;
  localparam logic [7:0] LVLS_RST_RST = 8'h81;
  localparam logic [7:0] LVLS_RST_INT = 8'h01;
  // Threshold levels selectable by option bits
  localparam int LEVEL_COUNT = 12;
  // Settling wait after an interrupt or a level change
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_TIME_NS = 10000;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 12;

  typedef enum logic [1:0] {SVM_OFF, SVM_INT, SVM_COMB, SVM_RST} svm_mode_t;
  typedef enum logic [1:0] {ST_INIT, ST_HOLD, ST_RUN} svm_state_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } svm_bus_req_t;

  typedef struct packed {
    logic upper_below;
    logic lower_below;
  } svm_cmp_t;
endpackage

//--- hw/svm_ctrl.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE_01: Option bits pick mode: 1,0 combined, 1,1 reset only, 0,1 interrupt only.
// RULE_02: Combined mode: upper level releases reset and interrupts, lower level resets.
// RULE_03: Reset-only mode: one threshold both asserts and releases reset.
// RULE_04: Interrupt-only mode: one threshold releases reset and raises interrupts.
// RULE_05: Combined: interrupt below upper, reset below lower, release at upper or above.
// RULE_06: Interrupt-only: first release at threshold, then interrupt on every crossing.
// RULE_07: Control bit 0 reads 1 while supply under selected threshold, else 0.
// RULE_08: A monitor-caused reset sets bit 0 of the reset-source register.
// RULE_09: Monitoring, resets and interrupts keep working in STOP mode.
// RULE_10: Twelve threshold levels come from option bits, not runtime registers.
// RULE_11: Control clears to 00H on reset; monitor reset keeps write-enable bit.
// RULE_12: Control bits 0 and 1 are read-only; writes to them are ignored.
// RULE_13: Write-enable high allows level-select writes and masks the monitor output.
// RULE_14: Software changes write-enable and mask only in combined mode; the code accepts write-enable writes in every mode.
// RULE_15: Combined mode only: mask flag high during enable, interrupt and level settling.
// RULE_16: Level-select bit 7 is mode: 0 interrupt, 1 reset.
// RULE_17: Level-select bit 0 low compares against the upper threshold.
// RULE_18: Level-select loads 00H, 01H or 81H on reset by source and mode.
// RULE_19: Other resets load 00H/81H/01H by mode; monitor reset keeps value.
// RULE_20: Level-select bit 0 high compares against lower or single threshold.
// RULE_21: Combined mode: after the interrupt, mode and level bits set to 1.
// RULE_22: Comparator outputs pass two flip-flops before any use.
// RULE_23: Each qualifying crossing gives one single-cycle interrupt pulse.
module svm_ctrl #(
  parameter int SETTLE_N = svm_pkg::SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire svm_pkg::svm_bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic opt_mode_sel_hi,
  input wire logic opt_mode_sel_lo,
  input wire logic [3:0] opt_level_code,
  input wire svm_pkg::svm_cmp_t cmp,
  output logic [3:0] level_code,
  output logic monitor_reset,
  output logic monitor_interrupt_request,
  output logic monitor_reset_source_flag
);
  import svm_pkg::*;

  svm_state_t state_r, state_nxt;
  svm_mode_t mode_r;
  logic [1:0] sync1_r, sync2_r, prev_r;
  logic we_r;
  logic [7:0] lvls_r, lvls_nxt;
  logic [SETTLE_W-1:0] settle_r, settle_nxt;
  logic [3:0] level_r;
  logic irq_r, irq_nxt;
  logic rsrc_r, rsrc_nxt;
  logic [7:0] rdata_r;

  // Option strap decode; only sampled in the first cycle after release
  wire svm_mode_t mode_w = !opt_mode_sel_lo ? (opt_mode_sel_hi ? SVM_COMB : SVM_OFF)
                         : (opt_mode_sel_hi ? SVM_RST : SVM_INT); // RULE_01
  wire logic [7:0] lvls_init = (mode_w == SVM_RST) ? LVLS_RST_RST :
                               (mode_w == SVM_INT) ? LVLS_RST_INT : LVLS_RST_COMB; // RULE_19

  // Synchronised comparator levels; stage one feeds stage two only
  wire logic up_below = sync2_r[1];
  wire logic lo_below = sync2_r[0];
  wire logic up_fall = up_below & ~prev_r[1];
  wire logic lo_cross = lo_below ^ prev_r[0];

  // Bus decode
  wire logic sel_ctrl = bus_req.addr == CTRL_ADDR;
  wire logic sel_lvls = bus_req.addr == LVLS_ADDR;
  wire logic sel_rsrc = bus_req.addr == RSRC_ADDR;
  wire logic wr_ctrl = bus_req.wr & sel_ctrl;
  wire logic wr_lvls = bus_req.wr & sel_lvls & we_r; // RULE_13
  wire logic lvl_change = wr_lvls & (bus_req.wdata[LVLS_LEVEL_BIT] != lvls_r[LVLS_LEVEL_BIT]);

  // Mask status exists only in combined mode
  wire logic comb = mode_r == SVM_COMB;
  wire logic mask_w = comb & (we_r | (settle_r != '0)); // RULE_15
  wire logic running = state_r == ST_RUN;
  wire logic in_hold = state_r == ST_HOLD;

  // Selected comparator: level bit low means upper threshold
  wire logic sel_below = lvls_r[LVLS_LEVEL_BIT] ? lo_below : up_below; // RULE_17 RULE_20
  wire logic flag_w = (mode_r != SVM_OFF) & running & sel_below; // RULE_07

  // Release condition per mode
  wire logic release_ok = comb ? ~up_below : ~lo_below; // RULE_02 RULE_05
  // Reset assertion per mode; a masked output holds back new resets
  wire logic go_hold = running & ((comb & lo_below & ~mask_w) | ((mode_r == SVM_RST) & lo_below)); // RULE_03 RULE_05

  // Interrupt qualifiers per mode
  wire logic comb_irq = comb & up_fall & ~mask_w & ~lvls_r[LVLS_MODE_BIT]; // RULE_05 RULE_16
  wire logic int_irq = (mode_r == SVM_INT) & lo_cross; // RULE_06
  wire logic irq_evt = running & ~go_hold & (comb_irq | int_irq);

  // Control readback: cleared image while the monitor holds reset, except write enable
  wire logic [7:0] ctrl_rd = {we_r, 5'h00, mask_w & ~in_hold, flag_w}; // RULE_11 RULE_12
  wire logic [7:0] rd_mux = sel_ctrl ? ctrl_rd :
                            sel_lvls ? lvls_r :
                            sel_rsrc ? {7'h00, rsrc_r} : 8'h00;

  // Two-stage synchroniser and edge history.
  // Stages start as "below" so the hold cannot end before a real reading has come through.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 2'h3;
      sync2_r <= 2'h3;
      prev_r <= 2'h3;
    end else begin
      sync1_r <= {cmp.upper_below, cmp.lower_below}; // RULE_22
      sync2_r <= sync1_r; // RULE_22
      prev_r <= sync2_r;
    end
  end

  // Sequencer: init, reset held, running. No clock gating, so it runs in STOP as well.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT: state_nxt = (mode_w == SVM_OFF) ? ST_RUN : ST_HOLD; // RULE_09
      ST_HOLD: if (release_ok) begin
        state_nxt = ST_RUN; // RULE_04 RULE_06
      end
      ST_RUN: if (go_hold) begin
        state_nxt = ST_HOLD;
      end
      default: state_nxt = ST_INIT;
    endcase
  end

  // Level-select next value: init load, gated write, automatic set after interrupt
  always_comb begin
    lvls_nxt = lvls_r;
    if (state_r == ST_INIT) begin
      lvls_nxt = lvls_init; // RULE_18 RULE_19
    end else if (irq_evt & comb) begin
      lvls_nxt[LVLS_MODE_BIT] = 1'b1; // RULE_21
      lvls_nxt[LVLS_LEVEL_BIT] = 1'b1; // RULE_21
    end else if (wr_lvls) begin
      lvls_nxt[LVLS_MODE_BIT] = bus_req.wdata[LVLS_MODE_BIT];
      lvls_nxt[LVLS_LEVEL_BIT] = bus_req.wdata[LVLS_LEVEL_BIT];
    end
  end

  // Settling counter restarts on the interrupt and on a level change, in combined mode only
  always_comb begin
    settle_nxt = settle_r;
    if ((irq_evt & comb) | (lvl_change & comb)) begin
      settle_nxt = SETTLE_W'(SETTLE_N); // RULE_15
    end else if (settle_r != '0) begin
      settle_nxt = settle_r - SETTLE_W'(1);
    end
  end

  // Reset-source bit: set wins over the clear-on-read
  always_comb begin
    rsrc_nxt = rsrc_r;
    if (bus_req.rd & sel_rsrc) begin
      rsrc_nxt = 1'b0;
    end
    if (go_hold) begin
      rsrc_nxt = 1'b1; // RULE_08
    end
  end

  assign irq_nxt = irq_evt; // RULE_23

  // Sequencer, mode and level registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_INIT;
      mode_r <= SVM_OFF;
      level_r <= 4'h0;
      lvls_r <= LVLS_RST_COMB;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_INIT) begin
        mode_r <= mode_w;
        level_r <= (opt_level_code < 4'(LEVEL_COUNT)) ? opt_level_code : 4'h0; // RULE_10
      end
      lvls_r <= lvls_nxt;
    end
  end

  // Write enable survives a monitor reset, since only rst_n or a control write clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      we_r <= 1'b0; // RULE_11
    end else if (wr_ctrl) begin
      we_r <= bus_req.wdata[CTRL_WE_BIT]; // RULE_12 RULE_14
    end
  end

  // Settling, interrupt, flag and read data registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_r <= '0;
      irq_r <= 1'b0;
      rsrc_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      settle_r <= settle_nxt;
      irq_r <= irq_nxt;
      rsrc_r <= rsrc_nxt;
      rdata_r <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  assign rdata = rdata_r;
  assign level_code = level_r;
  assign monitor_reset = in_hold;
  assign monitor_interrupt_request = irq_r;
  assign monitor_reset_source_flag = rsrc_r;

  mode_load_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    (state_r == ST_INIT) |=> (mode_r == $past(mode_w)))
    else $error("mode not taken from option bits");

  comb_irq_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
    (running && comb && up_fall && !mask_w && !lvls_r[7] && !lo_below) |=> monitor_interrupt_request)
    else $error("combined mode interrupt missing");

  rst_mode_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    (running && mode_r == SVM_RST && lo_below) |=> monitor_reset)
    else $error("reset-only mode did not reset");

  int_norst_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
    (running && mode_r == SVM_INT) |=> running)
    else $error("interrupt-only mode left run state");

  rsrc_set_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
    (running ##1 in_hold) |-> monitor_reset_source_flag)
    else $error("reset source flag not set");

  sync_two_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_22
    $rose(up_below) |-> $past(cmp.upper_below, 2))
    else $error("comparator used before two stages");

  irq_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_23
    monitor_interrupt_request |=> !monitor_interrupt_request)
    else $error("interrupt longer than one cycle");

  auto_bits_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_21
    (monitor_interrupt_request && comb) |-> (lvls_r[7] && lvls_r[0] && settle_r != '0))
    else $error("level bits not set after interrupt");

  mask_only_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
    (mode_r != SVM_COMB) |-> !ctrl_rd[1])
    else $error("mask flag outside combined mode");

  lvls_lock_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
    (running && bus_req.wr && sel_lvls && !we_r && !irq_evt) |=> $stable(lvls_r))
    else $error("level select written while locked");

  // Release, flag and register guards; all sampled in the system clock domain
  rel_upper_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
    (in_hold && comb && !up_below) |=> !monitor_reset)
    else $error("combined mode reset not released at upper level");

  rel_single_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
    (in_hold && !comb && !lo_below) |=> !monitor_reset)
    else $error("single level reset not released");

  rst_noirq_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    (mode_r == SVM_RST) |-> !monitor_interrupt_request)
    else $error("interrupt raised in reset-only mode");

  int_cross_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
    (running && mode_r == SVM_INT && lo_cross) |=> monitor_interrupt_request)
    else $error("interrupt-only crossing gave no interrupt");

  flag_sel_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    (running && mode_r != SVM_OFF) |-> (ctrl_rd[0] == sel_below))
    else $error("detection flag does not follow selected level");

  flag_off_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    (!running || mode_r == SVM_OFF) |-> !ctrl_rd[0])
    else $error("detection flag set while monitor idle");

  rsrc_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
    (monitor_reset_source_flag && !(bus_req.rd && sel_rsrc)) |=> monitor_reset_source_flag)
    else $error("reset source flag lost without a read");

  lvl_code_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
    (level_code < 4'(LEVEL_COUNT)))
    else $error("level code out of range");

  we_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
    (!wr_ctrl) |=> $stable(we_r))
    else $error("write enable changed without a write");

  ro_bits_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
    (ctrl_rd[6:2] == 5'h00))
    else $error("unused control bits not zero");

  mask_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
    (comb && we_r) |-> (!irq_evt && !go_hold))
    else $error("masked output still acted");

  settle_load_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
    (irq_evt && comb) |=> (settle_r == SETTLE_W'(SETTLE_N)))
    else $error("settling wait not started");

  mode_block_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
    (comb && lvls_r[LVLS_MODE_BIT]) |-> !irq_evt)
    else $error("interrupt raised in reset detection mode");

  lvls_init_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_19
    (state_r == ST_INIT) |=> (lvls_r == $past(lvls_init)))
    else $error("level select not loaded for mode");
endmodule
`default_nettype wire

//--- testbench/svm_supply_model.sv
`timescale 1ns/1ps
`default_nettype none
// Analog comparator pair: supply and thresholds in tenths of a volt
module svm_supply_model #(
  parameter int UPPER = 30,
  parameter int LOWER = 25
) (
  input wire logic [7:0] supply,
  output var svm_pkg::svm_cmp_t cmp
);
  import svm_pkg::*;
  // Outputs are asynchronous; the block synchronises them itself
  assign cmp.upper_below = (supply < UPPER);
  assign cmp.lower_below = (supply < LOWER);
endmodule
`default_nettype wire

//--- testbench/tb_svm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_svm_ctrl;
  import svm_pkg::*;
  logic clk, rst_n, hi, lo, irq, mrst, rflag;
  logic [3:0] lvl_in, lvl_out;
  logic [7:0] rdata, supply, irq_cnt, v;
  svm_bus_req_t req;
  svm_cmp_t cmp;
  int err_total, checked;
  svm_ctrl #(.SETTLE_N(4)) DUT (.clk(clk), .rst_n(rst_n), .bus_req(req), .rdata(rdata),
    .opt_mode_sel_hi(hi), .opt_mode_sel_lo(lo), .opt_level_code(lvl_in), .cmp(cmp),
    .level_code(lvl_out), .monitor_reset(mrst), .monitor_interrupt_request(irq),
    .monitor_reset_source_flag(rflag));
  svm_supply_model u_sup (.supply(supply), .cmp(cmp));
  // Clock at 100 ns
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // Pulse counter; a level held high would count many times
  always @(posedge clk) begin
    if (!rst_n) irq_cnt <= 0;
    else if (irq) irq_cnt <= irq_cnt + 1;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1;
    @(posedge clk);
    req.wr <= 0;
  endtask
  task rd(input logic [19:0] a);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1;
    @(posedge clk);
    req.rd <= 0;
    #1 v = rdata;
  endtask
  task do_reset(input logic h, input logic l, input logic [3:0] c, input logic [7:0] s);
    @(posedge clk);
    hi <= h;
    lo <= l;
    lvl_in <= c;
    supply <= s;
    rst_n <= 0;
    repeat (4) @(posedge clk);
    rst_n <= 1;
    repeat (8) @(posedge clk);
  endtask
  task step(input logic [7:0] s);
    @(posedge clk);
    supply <= s;
    repeat (10) @(posedge clk);
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog: the tests need well under 1000 cycles
  initial begin
    #(100 * 5000);
    err_total++;
    conclude;
  end
  initial begin
    rst_n = 0;
    req = '0;
    hi = 1;
    lo = 0;
    lvl_in = 4'h5;
    supply = 8'h21;
    err_total = 0;
    checked = 0;
    // Combined mode: software touches enable and mask only here
    do_reset(1, 0, 4'h5, 8'h21);
    chk(mrst, 0);
    chk(lvl_out, 4'h5);
    rd(CTRL_ADDR); chk(v, 8'h00);
    rd(LVLS_ADDR); chk(v, 8'h00);
    wr(CTRL_ADDR, 8'h83);
    rd(CTRL_ADDR); chk(v, 8'h82);
    wr(LVLS_ADDR, 8'hFF);
    rd(LVLS_ADDR); chk(v, 8'h81);
    wr(LVLS_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h00);
    repeat (8) @(posedge clk);
    rd(CTRL_ADDR); chk(v, 8'h00);
    wr(LVLS_ADDR, 8'h81);
    rd(LVLS_ADDR); chk(v, 8'h00);
    step(8'h1C);
    chk(irq_cnt, 8'h01);
    rd(LVLS_ADDR); chk(v, 8'h81);
    step(8'h14);
    chk(mrst, 1);
    chk(rflag, 1);
    rd(RSRC_ADDR); chk(v, 8'h01);
    step(8'h21);
    chk(mrst, 0);
    chk(irq_cnt, 8'h01);
    // Mode bit now set: an upper crossing must stay silent, lower level is compared
    step(8'h1C);
    chk(irq_cnt, 8'h01);
    chk(mrst, 0);
    rd(CTRL_ADDR); chk(v, 8'h00);
    $display("test combined done");
    // Reset-only mode: one threshold both ways, no interrupts
    do_reset(1, 1, 4'h3, 8'h14);
    chk(mrst, 1);
    rd(LVLS_ADDR); chk(v, 8'h81);
    chk(rflag, 0);
    step(8'h21);
    chk(mrst, 0);
    step(8'h14);
    chk(mrst, 1);
    chk(irq_cnt, 8'h00);
    chk(rflag, 1);
    $display("test reset_only done");
    // Interrupt-only mode; out-of-range level code folds to 0
    do_reset(0, 1, 4'hC, 8'h21);
    chk(mrst, 0);
    chk(lvl_out, 4'h0);
    rd(LVLS_ADDR); chk(v, 8'h01);
    step(8'h14);
    chk(irq_cnt, 8'h01);
    chk(mrst, 0);
    rd(CTRL_ADDR); chk(v, 8'h01);
    step(8'h21);
    chk(irq_cnt, 8'h02);
    rd(CTRL_ADDR); chk(v, 8'h00);
    rd(20'hFFFA0); chk(v, 8'h00);
    $display("test interrupt_only done");
    conclude;
  end
endmodule
`default_nettype wire
